// [design/cmt_timer.sv]
// Top of the cycle-measurement timer: APB registers, up-counter, capture and limit flags.
//
// Behaviour
// - Measure mode: capture below lower limit sets the underflow flag.
// - Flag clears by reading it at 1 then writing 0.
// - Status event flags accept only 0 writes; writing 1 keeps them.
// - Measure clock polarity bit: 0 inverts input, 1 uses it directly.
// - Status bit 0 is reserved, resets to 0, no function.
// - Control register is 8-bit and readable; only bits 7:5 are writable, the rest read 0.
// - Timer mode: start bit 1 counts up, 0 stops.
// - Timer mode: clearing start bit zeroes counter and halts capture.
// - Capture polarity bit: 0 uses input directly, 1 inverts.
// - Measure mode: stop-on-limit bit chooses halt or continue after limit flags.
// - Stop-on-limit bit has no effect in timer mode.
// - Measure mode: capture above upper limit sets the overflow flag.
// - Mode bit 0 timer, 1 measure; writing 1 starts counting.
`timescale 1ns/1ps
`default_nettype none
module cmt_timer
    import cmt_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input  wire logic          i_mclk,
    input  wire logic          i_reset_n,
    input  wire logic          i_ce,
    input  wire logic          i_psel,
    input  wire logic          i_penable,
    input  wire logic          i_pwrite,
    input  wire logic [7:0]    i_paddr,
    input  wire logic [31:0]   i_pwdata,
    input  wire logic [3:0]    i_pstrb,
    input  wire logic          i_capture_waveform_input,
    input  wire logic          i_measure_clock_input,
    output var  logic [31:0]   o_prdata,
    output var  logic          o_pready,
    output var  logic          o_pslverr,
    output var  logic          o_counting,
    output var  logic          o_measure_clock
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]    status_q;
    logic [7:0]    armed_q;
    logic [7:0]    control_q;
    logic          mode_q;
    logic [CW-1:0] lower_q;
    logic [CW-1:0] upper_q;
    logic [CW-1:0] capture_q;
    logic [CW-1:0] counter_q;
    logic          first_edge_q;
    logic          mclk_meta_q;
    logic          mclk_sync_q;

    cmt_edge_if cap_edge ();

    cmt_edge_sync u_cap_sync (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_pin     (i_capture_waveform_input),
        .i_invert  (control_q[CT_CAP_POL]),
        .o_edge    (cap_edge)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire access   = i_psel & i_penable & ~o_pready & i_ce;
    wire wr       = access & i_pwrite & i_pstrb[0];
    wire rd       = access & ~i_pwrite;
    wire sel_st   = (i_paddr == ADDR_STATUS);
    wire sel_ct   = (i_paddr == ADDR_CONTROL);
    wire sel_lo   = (i_paddr == ADDR_LOWER);
    wire sel_up   = (i_paddr == ADDR_UPPER);
    wire sel_cap  = (i_paddr == ADDR_CAPTURE);
    wire sel_cnt  = (i_paddr == ADDR_COUNTER);
    wire sel_md   = (i_paddr == ADDR_MODE);
    wire mapped   = sel_st | sel_ct | sel_lo | sel_up | sel_cap | sel_cnt | sel_md;
    wire wr_lo16  = wr & (i_pstrb[1:0] == 2'b11);

    wire measure  = mode_q;
    wire running  = measure | control_q[CT_START];
    wire stop_lim = measure & control_q[CT_STOP_LIMIT]
                  & (status_q[ST_UPPER_OVF] | status_q[ST_LOWER_UDF]);
    // Halting is not latched; it follows the flags while the stop-on-limit bit is set, so counting resumes once neither flag is set.
    wire active   = running & ~stop_lim;
    wire edge_hit = active & cap_edge.rise;

    // In measure mode the first edge opens the window and the second captures.
    wire take_cap = edge_hit & (~measure | first_edge_q);
    wire set_udf  = measure & take_cap & (counter_q < lower_q);
    wire set_ovf  = measure & take_cap & (counter_q > upper_q);

    // Event flags: bits that hardware sets and software clears by 0 writes.
    localparam logic [7:0] EVT_MASK = (8'h01 << ST_UPPER_OVF) | (8'h01 << ST_CAPTURE_EVT) | (8'h01 << ST_LOWER_UDF);
    wire [7:0] evt_set = ({7'h00, set_ovf} << ST_UPPER_OVF) | ({7'h00, take_cap} << ST_CAPTURE_EVT)
                       | ({7'h00, set_udf} << ST_LOWER_UDF);
    // Clearing needs a prior read at 1 so a flag raised after the read is never lost.
    wire [7:0] evt_clr = (wr & sel_st) ? (armed_q & ~i_pwdata[7:0] & EVT_MASK) : 8'h00;
    wire [7:0] st_d    = ((status_q & ~evt_clr) | evt_set) & EVT_MASK;
    wire       mpol_d  = (wr & sel_st) ? i_pwdata[ST_MCLK_POL] : status_q[ST_MCLK_POL];

    wire [31:0] rdata =
        sel_st  ? {24'h00_0000, status_q}              :
        sel_ct  ? {24'h00_0000, control_q}             :
        sel_lo  ? {{(32-CW){1'b0}}, lower_q}           :
        sel_up  ? {{(32-CW){1'b0}}, upper_q}           :
        sel_cap ? {{(32-CW){1'b0}}, capture_q}         :
        sel_cnt ? {{(32-CW){1'b0}}, counter_q}         :
        sel_md  ? {31'h0000_0000, mode_q}              : 32'h0000_0000;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else if (i_ce) begin
            o_pready  <= access;
            o_pslverr <= access & ~mapped;
            if (rd) begin
                o_prdata <= rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers and flags
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            status_q  <= REG8_RESET;
            armed_q   <= REG8_RESET;
            control_q <= REG8_RESET;
            mode_q    <= 1'b0;
            lower_q   <= CNT_RESET;
            upper_q   <= UPPER_RESET;
        end else if (i_ce) begin
            status_q                 <= st_d;
            status_q[ST_MCLK_POL]    <= mpol_d;
            status_q[ST_RESERVED]    <= 1'b0;
            if (rd & sel_st) begin
                armed_q <= status_q & EVT_MASK;
            end else if (wr & sel_st) begin
                armed_q <= REG8_RESET;
            end
            if (wr & sel_ct) begin
                control_q <= i_pwdata[7:0] & 8'hE0;
            end
            if (wr & sel_md) begin
                mode_q <= i_pwdata[MD_MEASURE];
            end
            if (wr_lo16 & sel_lo) begin
                lower_q <= i_pwdata[CW-1:0];
            end
            if (wr_lo16 & sel_up) begin
                upper_q <= i_pwdata[CW-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Counter and capture
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            counter_q    <= CNT_RESET;
            capture_q    <= CNT_RESET;
            first_edge_q <= 1'b0;
        end else if (i_ce) begin
            if (!running) begin
                counter_q    <= CNT_RESET;
                first_edge_q <= 1'b0;
            end else if (take_cap) begin
                capture_q    <= counter_q;
                counter_q    <= measure ? CNT_RESET : counter_q + 1'b1;
                first_edge_q <= measure;
            end else if (edge_hit) begin
                counter_q    <= CNT_RESET;
                first_edge_q <= 1'b1;
            end else if (active) begin
                counter_q <= counter_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Measurement clock and status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            mclk_meta_q     <= 1'b0;
            mclk_sync_q     <= 1'b0;
            o_measure_clock <= 1'b0;
            o_counting      <= 1'b0;
        end else if (i_ce) begin
            mclk_meta_q     <= i_measure_clock_input;
            mclk_sync_q     <= mclk_meta_q;
            o_measure_clock <= mclk_sync_q ^ ~status_q[ST_MCLK_POL];
            o_counting      <= active;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_UDF_SET: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        set_udf && i_ce |=> status_q[ST_LOWER_UDF])
        else $error("underflow flag not set");
    AST_OVF_SET: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        set_ovf && i_ce |=> status_q[ST_UPPER_OVF])
        else $error("overflow flag not set");
    AST_NO_CLR_UNREAD: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        status_q[ST_LOWER_UDF] && !armed_q[ST_LOWER_UDF] |=> status_q[ST_LOWER_UDF])
        else $error("flag cleared without prior read");
    AST_WR1_KEEPS: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !status_q[ST_UPPER_OVF] && !set_ovf |=> !status_q[ST_UPPER_OVF])
        else $error("flag set by software");
    AST_RSVD_ZERO: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        status_q[ST_RESERVED] == 1'b0)
        else $error("reserved bit set");
    AST_CT_WRITE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        wr && sel_ct |=> control_q == ($past(i_pwdata[7:0]) & 8'hE0))
        else $error("control write lost");
    AST_STOP_ZERO: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !running && i_ce |=> counter_q == CNT_RESET)
        else $error("counter not cleared on stop");
    AST_COUNT_UP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        active && !edge_hit && i_ce |=> counter_q == $past(counter_q) + 1'b1)
        else $error("counter did not advance");
    AST_LIMIT_HALT: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        stop_lim && i_ce |=> $stable(counter_q) && $stable(capture_q))
        else $error("counting continued after limit");
    AST_TIMER_IGNORES: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !measure && control_q[CT_START] && i_ce |-> active)
        else $error("stop bit affected timer mode");
    AST_MCLK_POL: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && $past(i_ce) |=> o_measure_clock == ($past(mclk_sync_q) ^ ~$past(status_q[ST_MCLK_POL])))
        else $error("measure clock polarity wrong");

    COV_CAPTURE: cover property (@(posedge i_mclk) disable iff (!i_reset_n) take_cap);
    COV_UNDERFLOW: cover property (@(posedge i_mclk) disable iff (!i_reset_n) set_udf);
    COV_OVERFLOW: cover property (@(posedge i_mclk) disable iff (!i_reset_n) set_ovf);
    COV_FLAG_CLEAR: cover property (@(posedge i_mclk) disable iff (!i_reset_n) evt_clr != 8'h00);
endmodule : cmt_timer
`default_nettype wire

// [design/cmt_pkg.sv]
// Package of register map, field positions and reset values for the cycle-measurement timer.
`default_nettype none
package cmt_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_LOWER   = 8'h08;
    localparam logic [7:0] ADDR_UPPER   = 8'h0C;
    localparam logic [7:0] ADDR_CAPTURE = 8'h10;
    localparam logic [7:0] ADDR_COUNTER = 8'h14;
    localparam logic [7:0] ADDR_MODE    = 8'h18;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ST_UPPER_OVF   = 6;
    localparam int ST_CAPTURE_EVT = 3;
    localparam int ST_LOWER_UDF   = 2;
    localparam int ST_MCLK_POL    = 1;
    localparam int ST_RESERVED    = 0;
    localparam int CT_START       = 7;
    localparam int CT_CAP_POL     = 6;
    localparam int CT_STOP_LIMIT  = 5;
    localparam int MD_MEASURE     = 0;
    // ------------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG8_RESET  = 8'h00;
    localparam logic [15:0] CNT_RESET   = 16'h0000;
    localparam logic [15:0] UPPER_RESET = 16'hFFFF;
    localparam int          CNT_W       = 16;
endpackage : cmt_pkg
`default_nettype wire

// [design/cmt_edge_if.sv]
// Interface carrying the synchronised, polarity-adjusted capture edge between modules.
`timescale 1ns/1ps
`default_nettype none
interface cmt_edge_if;
    logic level;
    logic rise;
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface : cmt_edge_if
`default_nettype wire

// [design/cmt_edge_sync.sv]
// Two-flop synchroniser with polarity select and rising-edge detect.
`timescale 1ns/1ps
`default_nettype none
module cmt_edge_sync (
    input  wire logic  i_mclk,
    input  wire logic  i_reset_n,
    input  wire logic  i_ce,
    input  wire logic  i_pin,
    input  wire logic  i_invert,
    cmt_edge_if.src    o_edge
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    wire  polar = sync_q ^ i_invert;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (i_ce) begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            prev_q <= polar;
        end
    end

    assign o_edge.level = polar;
    assign o_edge.rise  = polar & ~prev_q & i_ce;
endmodule : cmt_edge_sync
`default_nettype wire

// [tb/cmt_wave_src.sv]
// Model of the external waveform sources that drive the timer's two input pins.
`timescale 1ns/1ps
`default_nettype none
module cmt_wave_src (
    input  wire logic       i_mclk,
    input  wire logic       i_run,
    input  wire logic       i_idle_lvl,
    input  wire logic [7:0] i_half,
    output var  logic       o_capture_wave,
    output var  logic       o_measure_clock
);
    logic [7:0] cnt_q = 8'h00;
    initial begin
        o_capture_wave = 1'b0;
        o_measure_clock = 1'b0;
    end
    // The wave stands low outside a burst, so a burst always starts on a clean rising edge.
    always @(posedge i_mclk) begin
        o_measure_clock <= i_idle_lvl;
        if (!i_run) begin
            cnt_q <= 8'h00;
            o_capture_wave <= 1'b0;
        end else if (cnt_q == i_half - 8'h01) begin
            cnt_q <= 8'h00;
            o_capture_wave <= ~o_capture_wave;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : cmt_wave_src
`default_nettype wire

// [tb/cmt_timer_tb_top.sv]
// Self-checking testbench of the cycle-measurement timer.
`timescale 1ns/1ps
`default_nettype none
module cmt_timer_tb_top;
    import cmt_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        run = 1'b0;
    logic        idle = 1'b0;
    logic        cap_wave;
    logic        mclk_in;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        counting;
    logic        mclk_out;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          num_checks = 0;
    always #5 clk = ~clk;
    cmt_timer i_cmt_timer (.i_mclk(clk), .i_reset_n(rst_n), .i_ce(1'b1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(4'hf), .i_capture_waveform_input(cap_wave), .i_measure_clock_input(mclk_in),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_counting(counting),
        .o_measure_clock(mclk_out));
    cmt_wave_src i_cmt_wave_src (.i_mclk(clk), .i_run(run), .i_idle_lvl(idle), .i_half(8'h0a),
        .o_capture_wave(cap_wave), .o_measure_clock(mclk_in));
    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // A wait for pready is bounded, so a dead slave ends the run instead of hanging it.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk("pready_timeout", {31'h0, pready}, 32'h0000_0001);
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd_reg
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_reg(ADDR_STATUS);
        chk("status", rd, 32'h0000_0000);
        rd_reg(ADDR_CONTROL);
        chk("control", rd, 32'h0000_0000);
        rd_reg(ADDR_UPPER);
        chk("upper", rd, 32'h0000_ffff);
        chk("counting", {31'h0, counting}, 32'h0000_0000);
    endtask : t_reset
    task automatic t_ctrl_rw();
        wr_reg(ADDR_CONTROL, 32'h0000_0060);
        rd_reg(ADDR_CONTROL);
        chk("control", rd, 32'h0000_0060);
        wr_reg(ADDR_CONTROL, 32'h0000_001f);
        rd_reg(ADDR_CONTROL);
        chk("control", rd, 32'h0000_0000);
        rd_reg(8'hfc);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    endtask : t_ctrl_rw
    task automatic t_mclk_pol();
        for (int k = 0; k < 4; k++) begin
            wr_reg(ADDR_STATUS, (k % 2) ? 32'h0000_0002 : 32'h0000_0000);
            idle <= (k / 2) ? 1'b1 : 1'b0;
            repeat (8) @(posedge clk);
            chk("mclk", {31'h0, mclk_out}, {31'h0, ((k % 2) ? idle : ~idle)});
        end
    endtask : t_mclk_pol
    task automatic t_timer_run();
        wr_reg(ADDR_CONTROL, 32'h0000_00a0);
        repeat (40) @(posedge clk);
        chk("counting", {31'h0, counting}, 32'h0000_0001);
        rd_reg(ADDR_COUNTER);
        chk("count_high", {31'h0, rd[15:0] >= 16'h0028}, 32'h0000_0001);
        wr_reg(ADDR_CONTROL, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("counting", {31'h0, counting}, 32'h0000_0000);
        rd_reg(ADDR_COUNTER);
        chk("count", rd, 32'h0000_0000);
    endtask : t_timer_run
    task automatic clear_flags(input int b);
        // The caller's status read armed the flags, so this write of ones must leave them set.
        wr_reg(ADDR_STATUS, 32'h0000_00fe);
        // That write disarmed them, so a zero write with no fresh read must not clear either.
        wr_reg(ADDR_STATUS, 32'h0000_0002);
        rd_reg(ADDR_STATUS);
        chk("flag_kept", {31'h0, rd[b]}, 32'h0000_0001);
        chk("flag_unread", {31'h0, rd[b]}, 32'h0000_0001);
        wr_reg(ADDR_STATUS, 32'h0000_0002);
        rd_reg(ADDR_STATUS);
        chk("status", rd, 32'h0000_0002);
    endtask : clear_flags
    // Limits of 1000 and 5 sit far from the 20-cycle period, so sync jitter cannot flip them.
    task automatic t_measure(input logic [15:0] lo, input logic [15:0] hi, input logic stop);
        wr_reg(ADDR_LOWER, {16'h0, lo});
        wr_reg(ADDR_UPPER, {16'h0, hi});
        wr_reg(ADDR_CONTROL, {26'h0, stop, 5'h00});
        wr_reg(ADDR_MODE, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("counting", {31'h0, counting}, 32'h0000_0001);
        run <= 1'b1;
        repeat (120) @(posedge clk);
        chk("counting", {31'h0, counting}, {31'h0, ~stop});
        run <= 1'b0;
        wr_reg(ADDR_MODE, 32'h0000_0000);
        rd_reg(ADDR_STATUS);
        chk("lower_flag", {31'h0, rd[2]}, {31'h0, lo != 16'h0000});
        chk("upper_flag", {31'h0, rd[6]}, {31'h0, lo == 16'h0000});
        rd_reg(ADDR_CAPTURE);
        chk("capture_period", {31'h0, rd[15:0] > 16'h0010 && rd[15:0] < 16'h0018}, 32'h0000_0001);
        clear_flags((lo != 16'h0000) ? 2 : 6);
        wr_reg(ADDR_CONTROL, 32'h0000_0000);
    endtask : t_measure
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ctrl_rw();
        t_mclk_pol();
        t_timer_run();
        t_measure(16'h03e8, 16'hffff, 1'b0);
        t_measure(16'h0000, 16'h0005, 1'b1);
        t_measure(16'h0000, 16'h0005, 1'b0);
        report_and_stop();
    end
endmodule : cmt_timer_tb_top
`default_nettype wire
